/* File: hdl/homing_consts.vh */
`ifndef HOMING_CONSTS_VH
`define HOMING_CONSTS_VH
// register byte offsets
`define A_CTRL      8'h00
`define A_STATUS    8'h04
`define A_HSPEED    8'h08
`define A_CSPEED    8'h0C
`define A_CFG       8'h10
`define A_SHIFT     8'h14
`define A_HOMECOORD 8'h18
`define A_WINDOW    8'h1C
`define A_OTDECEL   8'h20
`define A_STPTIME   8'h24
`define A_STPTORQ   8'h28
`define A_SLPOS     8'h2C
`define A_SLNEG     8'h30
`define A_POS       8'h34
`define A_REVAMT    8'h38
// cfg field positions
`define F_START_DIR  0
`define F_HOME_DIR   2
`define F_SHIFT_REF  4
`define F_HOME_REF   8
`define F_EDGE       10
`define F_CREEP_REV  11
`define F_OT_ACT     12
`define F_SL_SEL     13
`define F_MODE       16
// reset values
`define RST_HSPEED   32'h0000C350
`define RST_CSPEED   32'h00001388
`define RST_CFG      32'h00000010
`define RST_SHIFT    32'h000003E8
`define RST_OTDECEL  32'h000003E8
`define RST_SLPOS    32'h0BEBC200
`define RST_SLNEG    32'h88CA6C00
// timing: ms at 100 MHz
`define T_MS_NS      1000000
`define CLK_NS       10
`define CYC_PER_MS   (`T_MS_NS / `CLK_NS)
`define STP_TIME_MAX 32'h00002710
`define STP_TORQ_MAX 32'h00000064
// 2000 r/min expressed in 0.01 r/min speed units
`define RPM_REF      32'h00030D40
`endif

/* File: hdl/edge_sync.v */
`timescale 1ns/1ps
module edge_sync #(
   parameter W = 6
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         ce,
   input  wire [W-1:0] din,
   output wire [W-1:0] level,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
      end else if (ce) begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign level = s2_r;
   assign rise  = s2_r & ~s3_r;
   assign fall  = ~s2_r & s3_r;
endmodule

/* File: hdl/homing_sequencer_soft_limit.v */
// Behaviour
// - power-cycle settings latched once after reset
// - request rise starts homing speed, start direction
// - reference seen: creep speed, homing direction
// - index then shift travel, stop, complete
// - start direction: forward, reverse, conditional
// - homing direction picks home side
// - shift reference selector six sources
// - homing reference selector: switch, +OT, -OT
// - switch edge: turning on or off
// - index-only homing runs creep from start
// - overtravel: reverse or stop and abandon
// - stopper time and torque recognise contact
// - soft limits force stop when enabled
// - modes 0-6: selector enables soft limits
// - mode 7: selector picks command format
// - positive limit resets to 200000000
// - negative limit resets to -2000000000
// - success loads home coordinate into position
// - completion gated by window, zero means always
// - ot decel time scaled from 2000 r/min
// - creep reverse backs up then re-approaches
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "homing_consts.vh"
module homing_sequencer_soft_limit (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   // apb
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // sensors
   input  wire        homing_request,
   input  wire        home_switch,
   input  wire        pos_overtravel_in,
   input  wire        neg_overtravel_in,
   input  wire        index_pulse,
   input  wire        interrupt_in,
   input  wire        torque_at_limit,
   input  wire        pos_step,
   input  wire        neg_step,
   // motion commands
   output reg  [31:0] speed_cmd,
   output reg         dir_reverse,
   output reg         motion_stop,
   output reg  [31:0] torque_limit_cmd,
   output reg  [31:0] decel_time_cmd,
   output reg         zero_preset_fmt,
   output reg         homing_complete,
   output reg         soft_limit_stop
);
   localparam S_IDLE  = 7'b0000001;
   localparam S_FAST  = 7'b0000010;
   localparam S_CREEP = 7'b0000100;
   localparam S_BACK  = 7'b0001000;
   localparam S_SHIFT = 7'b0010000;
   localparam S_DONE  = 7'b0100000;
   localparam S_ABORT = 7'b1000000;

   reg  [6:0]  st_r;
   reg  [31:0] hspeed_r, cspeed_r, cfg_r, cfg_live_r, shift_r, coord_r;
   reg  [31:0] window_r, otdecel_r, stptime_r, stptorq_r, slpos_r, slneg_r;
   reg  [31:0] revamt_r, pos_r, home_r, dist_r, stpcnt_r;
   reg         latched_r, homed_r, ref_seen_r, ot_seen_r, req_abort_r;
   wire [5:0]  lvl, rise, fall;
   wire        req_rise = rise[0];

   edge_sync #(.W(6)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (clk_en),
      .din     ({torque_at_limit, interrupt_in, index_pulse,
                 neg_overtravel_in, pos_overtravel_in, homing_request}),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   wire [1:0] start_dir = cfg_r[`F_START_DIR+1:`F_START_DIR];
   wire       home_dir  = cfg_r[`F_HOME_DIR];
   wire [2:0] shift_ref = cfg_r[`F_SHIFT_REF+2:`F_SHIFT_REF];
   wire [1:0] home_ref  = cfg_r[`F_HOME_REF+1:`F_HOME_REF];
   wire       edge_sel  = cfg_r[`F_EDGE];
   wire       creep_rev = cfg_r[`F_CREEP_REV];
   wire       ot_act    = cfg_r[`F_OT_ACT];
   wire       sl_sel    = cfg_r[`F_SL_SEL];
   wire [2:0] mode      = cfg_r[`F_MODE+2:`F_MODE];

   reg hs_r, hs_p_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_r   <= 1'b0;
         hs_p_r <= 1'b0;
      end else if (clk_en) begin
         hs_r   <= home_switch;
         hs_p_r <= hs_r;
      end
   end
   reg hs_q_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hs_q_r <= 1'b0;
      else if (clk_en)
         hs_q_r <= hs_p_r;
   end
   wire sw_edge = edge_sel ? (~hs_p_r & hs_q_r) : (hs_p_r & ~hs_q_r);

   // decoded homing reference event
   function ref_hit;
      input [1:0] sel;
      input       sw, po, no;
      begin
         case (sel)
            2'd0:    ref_hit = sw;
            2'd1:    ref_hit = po;
            2'd2:    ref_hit = no;
            default: ref_hit = 1'b0;
         endcase
      end
   endfunction

   wire stopper_hit = lvl[5] && (stpcnt_r >= stptime_r * `CYC_PER_MS);
   reg  shift_hit;
   always @* begin
      case (shift_ref)
         3'd0:    shift_hit = sw_edge;
         3'd1:    shift_hit = rise[3];
         3'd2:    shift_hit = rise[1];
         3'd3:    shift_hit = rise[2];
         3'd4:    shift_hit = rise[4];
         3'd5:    shift_hit = stopper_hit;
         default: shift_hit = 1'b0;
      endcase
   end
   wire decel_hit = ref_hit(home_ref, sw_edge, rise[1], rise[2]);
   wire idx_only  = (shift_ref == 3'd1) && (home_ref == 2'd3);
   wire ot_hit    = (rise[1] & ~dir_reverse) | (rise[2] & dir_reverse);
   wire sl_en     = (mode != 3'd7) && sl_sel;
   wire over_pos  = $signed(pos_r) > $signed(slpos_r);
   wire over_neg  = $signed(pos_r) < $signed(slneg_r);
   wire sl_trip   = sl_en && (over_pos || over_neg);
   wire [31:0] off = pos_r - home_r;
   wire in_win = ($signed(off) <= $signed(window_r)) &&
                 ($signed(off) >= -$signed(window_r));
   wire start_rev = (start_dir == 2'd0) ? 1'b0 : (start_dir == 2'd1) ? 1'b1 :
                    (hs_p_r ? ~home_dir : home_dir);
   // ramp scaled from the 2000 r/min reference, product kept wide
   wire [63:0] decel_prod = hspeed_r * otdecel_r;
   wire [63:0] decel_full = decel_prod / {32'h00000000, `RPM_REF};

   // apb slave: one wait state, writes land on the completing edge
   wire wr = psel && penable && pwrite && pready;
   wire rd = psel && penable && !pwrite && !pready;
   wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `A_REVAMT);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0; pslverr <= 1'b0; prdata <= 32'h00000000;
         hspeed_r <= `RST_HSPEED; cspeed_r <= `RST_CSPEED;
         cfg_live_r <= `RST_CFG; shift_r <= `RST_SHIFT;
         coord_r <= 32'h00000000; window_r <= 32'h00000000;
         otdecel_r <= `RST_OTDECEL; stptime_r <= 32'h00000000;
         stptorq_r <= 32'h00000000; revamt_r <= 32'h00000000;
         slpos_r <= `RST_SLPOS;
         slneg_r <= `RST_SLNEG;
      end else if (clk_en) begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (wr && mapped) begin
            case (paddr)
               `A_HSPEED:    hspeed_r <= pwdata;
               `A_CSPEED:    cspeed_r <= pwdata;
               `A_CFG:       cfg_live_r <= pwdata;
               `A_SHIFT:     shift_r <= pwdata;
               `A_HOMECOORD: coord_r <= pwdata;
               `A_WINDOW:    window_r <= pwdata;
               `A_OTDECEL:   otdecel_r <= pwdata;
               `A_STPTIME:   stptime_r <= (pwdata > `STP_TIME_MAX) ?
                                `STP_TIME_MAX : pwdata;
               `A_STPTORQ:   stptorq_r <= (pwdata > `STP_TORQ_MAX) ?
                                `STP_TORQ_MAX : pwdata;
               `A_SLPOS:     slpos_r <= pwdata;
               `A_SLNEG:     slneg_r <= pwdata;
               `A_REVAMT:    revamt_r <= pwdata;
               default:      prdata <= prdata;
            endcase
         end
         if (rd) begin
            case (paddr)
               `A_CTRL:      prdata <= {31'h0, latched_r};
               `A_STATUS:    prdata <= {22'h0, soft_limit_stop,
                                homing_complete, homed_r, st_r};
               `A_HSPEED:    prdata <= hspeed_r;
               `A_CSPEED:    prdata <= cspeed_r;
               `A_CFG:       prdata <= cfg_live_r;
               `A_SHIFT:     prdata <= shift_r;
               `A_HOMECOORD: prdata <= coord_r;
               `A_WINDOW:    prdata <= window_r;
               `A_OTDECEL:   prdata <= otdecel_r;
               `A_STPTIME:   prdata <= stptime_r;
               `A_STPTORQ:   prdata <= stptorq_r;
               `A_SLPOS:     prdata <= slpos_r;
               `A_SLNEG:     prdata <= slneg_r;
               `A_POS:       prdata <= pos_r;
               `A_REVAMT:    prdata <= revamt_r;
               default:      prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // power-cycle settings follow the register until the first request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r     <= `RST_CFG;
         latched_r <= 1'b0;
      end else if (clk_en && !latched_r) begin
         cfg_r     <= cfg_live_r;
         latched_r <= req_rise;
      end else if (clk_en) begin
         cfg_r[`F_START_DIR+1:`F_START_DIR] <=
            cfg_live_r[`F_START_DIR+1:`F_START_DIR];
      end
   end

   wire wr_ctrl_abort = wr && (paddr == `A_CTRL) && pwdata[1];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= S_IDLE; pos_r <= 32'h00000000; home_r <= 32'h00000000;
         dist_r <= 32'h00000000; stpcnt_r <= 32'h00000000;
         homed_r <= 1'b0; ref_seen_r <= 1'b0; ot_seen_r <= 1'b0;
         req_abort_r <= 1'b0;
         speed_cmd <= 32'h00000000; dir_reverse <= 1'b0;
         motion_stop <= 1'b1; torque_limit_cmd <= 32'h00000000;
         decel_time_cmd <= 32'h00000000; zero_preset_fmt <= 1'b0;
         homing_complete <= 1'b0; soft_limit_stop <= 1'b0;
      end else if (clk_en) begin
         req_abort_r <= wr_ctrl_abort;
         if (pos_step && !neg_step)
            pos_r <= pos_r + 32'h00000001;
         else if (neg_step && !pos_step)
            pos_r <= pos_r - 32'h00000001;
         stpcnt_r <= lvl[5] ? stpcnt_r + 32'h00000001 : 32'h00000000;
         soft_limit_stop <= sl_trip;
         zero_preset_fmt <= (mode == 3'd7) && sl_sel;
         decel_time_cmd <= decel_full[31:0];
         torque_limit_cmd <= (shift_ref == 3'd5) ? stptorq_r : 32'h00000064;
         homing_complete <= homed_r &&
                            (window_r == 32'h00000000 || in_win);
         if (sl_trip || req_abort_r) begin
            st_r <= S_ABORT; homed_r <= 1'b0;
            motion_stop <= 1'b1; speed_cmd <= 32'h00000000;
         end else begin
            case (st_r)
               S_IDLE, S_DONE, S_ABORT: if (req_rise) begin
                  homed_r <= 1'b0; ref_seen_r <= 1'b0; ot_seen_r <= 1'b0;
                  motion_stop <= 1'b0;
                  dir_reverse <= start_rev;
                  speed_cmd <= idx_only ? cspeed_r : hspeed_r;
                  st_r <= idx_only ? S_CREEP : S_FAST;
               end
               S_FAST: if (ot_hit && ot_act) begin
                  st_r <= S_ABORT; motion_stop <= 1'b1;
                  speed_cmd <= 32'h00000000;
               end else if (ot_hit && !ot_seen_r) begin
                  ot_seen_r <= 1'b1; dir_reverse <= ~dir_reverse;
               end else if (creep_rev && shift_hit) begin
                  dir_reverse <= ~home_dir;
                  dist_r <= revamt_r; st_r <= S_BACK;
               end else if (decel_hit) begin
                  speed_cmd <= cspeed_r;
                  dir_reverse <= home_dir;
                  ref_seen_r <= 1'b1; st_r <= S_CREEP;
               end
               S_BACK: if (dist_r == 32'h00000000) begin
                  speed_cmd <= cspeed_r; dir_reverse <= home_dir;
                  ref_seen_r <= 1'b1; st_r <= S_CREEP;
               end else if (pos_step ^ neg_step)
                  dist_r <= dist_r - 32'h00000001;
               S_CREEP: if (ot_hit && ot_act) begin
                  st_r <= S_ABORT; motion_stop <= 1'b1;
                  speed_cmd <= 32'h00000000;
               end else if (shift_hit) begin
                  dist_r <= shift_r; st_r <= S_SHIFT;
               end
               S_SHIFT: if (dist_r == 32'h00000000) begin
                  motion_stop <= 1'b1; speed_cmd <= 32'h00000000;
                  home_r <= coord_r; homed_r <= 1'b1;
                  pos_r <= coord_r;
                  st_r <= S_DONE;
               end else if (pos_step ^ neg_step)
                  dist_r <= dist_r - 32'h00000001;
               default: st_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule

/* File: tb/homing_props.sv */
`timescale 1ns/1ps
module homing_props (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   // homing
   input wire        homing_request,
   input wire [31:0] speed_cmd,
   input wire        motion_stop,
   input wire [31:0] torque_limit_cmd,
   input wire        homing_complete,
   input wire        soft_limit_stop
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // access phase still waiting for its answer
   sequence access_wait;
      psel && penable && !pready;
   endsequence
   // request low, then high long enough to cross the synchroniser
   sequence req_rise;
      !homing_request ##1 homing_request [*3];
   endsequence
   apb_answer_a: assert property (access_wait |=> pready)
      else $error("apb answer late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   start_motion_a: assert property (
      (motion_stop && !soft_limit_stop) ##0 req_rise |-> ##[0:3] !motion_stop)
      else $error("homing did not start");
   moving_speed_a: assert property (
      $fell(motion_stop) |-> speed_cmd != 32'h0)
      else $error("motion started at zero speed");
   done_stopped_a: assert property (
      $rose(homing_complete) |-> motion_stop && !soft_limit_stop)
      else $error("completion while moving");
   soft_stop_a: assert property (
      $rose(soft_limit_stop) |-> ##[0:2] (motion_stop && !homing_complete))
      else $error("soft limit did not stop");
   torque_clamp_a: assert property (
      torque_limit_cmd <= 32'h00000064)
      else $error("torque limit above full scale");
endmodule
bind homing_sequencer_soft_limit homing_props i_homing_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .homing_request(homing_request),
   .speed_cmd(speed_cmd), .motion_stop(motion_stop),
   .torque_limit_cmd(torque_limit_cmd), .homing_complete(homing_complete),
   .soft_limit_stop(soft_limit_stop)
);

/* File: tb/motor_model.sv */
`timescale 1ns/1ps
module motor_model #(
   parameter HOME_AT = 100,
   parameter IDX     = 64,
   parameter FAST    = 2,
   parameter SLOW    = 8
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // commands from the drive
   input  wire [31:0] speed_cmd,
   input  wire        dir_reverse,
   input  wire        motion_stop,
   // encoder and sensors
   output reg         pos_step,
   output reg         neg_step,
   output wire        index_pulse,
   output wire        home_switch
);
   integer pos;
   integer div_r;
   integer gap;
   // index marks one place per turn, switch covers the positive side
   assign index_pulse = (pos % IDX) == 0;
   assign home_switch = pos >= HOME_AT;
   always @* gap = (speed_cmd > 32'h00001388) ? FAST : SLOW;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= 0;
         div_r <= 0;
         pos_step <= 1'b0;
         neg_step <= 1'b0;
      end else begin
         pos_step <= 1'b0;
         neg_step <= 1'b0;
         div_r <= div_r + 1;
         if (!motion_stop && speed_cmd != 32'h0 && div_r >= gap - 1) begin
            div_r <= 0;
            pos <= dir_reverse ? pos - 1 : pos + 1;
            pos_step <= !dir_reverse;
            neg_step <= dir_reverse;
         end
      end
   end
endmodule

/* File: tb/homing_sequencer_soft_limit_test.sv */
`timescale 1ns/1ps
`include "homing_consts.vh"
module homing_sequencer_soft_limit_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        hr = 1'b0;
   logic [31:0] q;
   logic        er;
   wire  [31:0] prdata, speed_cmd, tlc, dtc;
   wire         pready, pslverr, motion_stop, dir_reverse;
   wire         homing_complete, pos_step, neg_step, idx, sw, sls, zpf;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          i;
   // write flag, address, write data, expected read, expected error
   logic [73:0] rows [14] = '{
      {1'b0, `A_HSPEED, 32'h0, 32'h0000C350, 1'b0},
      {1'b0, `A_CSPEED, 32'h0, 32'h00001388, 1'b0},
      {1'b0, `A_CFG, 32'h0, 32'h00000010, 1'b0},
      {1'b0, `A_SHIFT, 32'h0, 32'h000003E8, 1'b0},
      {1'b0, `A_OTDECEL, 32'h0, 32'h000003E8, 1'b0},
      {1'b0, `A_SLPOS, 32'h0, 32'h0BEBC200, 1'b0},
      {1'b0, `A_SLNEG, 32'h0, 32'h88CA6C00, 1'b0},
      {1'b0, `A_POS, 32'h0, 32'h0, 1'b0},
      {1'b0, 8'h3C, 32'h0, 32'h0, 1'b1},
      {1'b1, 8'h11, 32'hFFFFFFFF, 32'h0, 1'b1},
      {1'b1, `A_STPTORQ, 32'h000000C8, 32'h00000064, 1'b0},
      {1'b1, `A_STPTIME, 32'h00004E20, 32'h00002710, 1'b0},
      {1'b1, `A_SHIFT, 32'h00000014, 32'h00000014, 1'b0},
      {1'b1, `A_HOMECOORD, 32'h0000007B, 32'h0000007B, 1'b0}};
   homing_sequencer_soft_limit i_homing_sequencer_soft_limit (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .homing_request(hr), .home_switch(sw), .pos_overtravel_in(1'b0),
      .neg_overtravel_in(1'b0), .index_pulse(idx), .interrupt_in(1'b0),
      .torque_at_limit(1'b0), .pos_step(pos_step), .neg_step(neg_step),
      .speed_cmd(speed_cmd), .dir_reverse(dir_reverse),
      .motion_stop(motion_stop), .torque_limit_cmd(tlc), .decel_time_cmd(dtc),
      .zero_preset_fmt(zpf), .homing_complete(homing_complete),
      .soft_limit_stop(sls));
   motor_model i_motor_model (
      .pclk(pclk), .presetn(presetn), .speed_cmd(speed_cmd),
      .dir_reverse(dir_reverse), .motion_stop(motion_stop),
      .pos_step(pos_step), .neg_step(neg_step), .index_pulse(idx),
      .home_switch(sw));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      wt(30000);
      error_cnt++;
      final_report;
   end
   // register rows, then homing runs
   initial begin
      logic [73:0] r;
      wt(5);
      chk("stop_in_reset", motion_stop, 32'h1);
      presetn <= 1'b1;
      wt(3);
      for (i = 0; i < 14; i++) begin
         r = rows[i];
         if (r[73]) apb(1'b1, r[72:65], r[64:33]);
         apb(1'b0, r[72:65], 32'h0);
         chk("prdata", q, r[32:1]);
         chk("pslverr", er, r[0]);
      end
      // soft limits on; power-cycle fields latch when this run starts
      apb(1'b1, `A_CFG, 32'h00002010);
      hr <= 1'b1;
      wt(8);
      chk("stop", motion_stop, 32'h0);
      chk("dir", dir_reverse, 32'h0);
      chk("speed", speed_cmd, 32'h0000C350);
      chk("torque", tlc, `STP_TORQ_MAX);
      chk("decel", dtc, 32'h000000FA);
      chk("fmt", zpf, 32'h0);
      for (i = 0; i < 2000 && i_motor_model.pos < 105; i++) wt(1);
      wt(6);
      chk("creep", speed_cmd, 32'h00001388);
      chk("home_dir", dir_reverse, 32'h0);
      for (i = 0; i < 9000 && homing_complete !== 1'b1; i++) wt(1);
      chk("complete", homing_complete, 32'h1);
      chk("stopped", motion_stop, 32'h1);
      chk("stop_pos", i_motor_model.pos, 32'h00000094);
      apb(1'b0, `A_POS, 32'h0);
      chk("position", q, 32'h0000007B);
      hr <= 1'b0;
      wt(3);
      // soft limits switched off live must wait for the next power-up
      apb(1'b1, `A_CFG, 32'h00000015);
      apb(1'b1, `A_SLPOS, 32'h00000064);
      wt(3);
      chk("soft_stop", sls, 32'h1);
      chk("soft_clear", homing_complete, 32'h0);
      apb(1'b1, `A_SLPOS, `RST_SLPOS);
      wt(2);
      chk("soft_free", sls, 32'h0);
      hr <= 1'b1;
      wt(8);
      chk("start_rev", dir_reverse, 32'h1);
      chk("cleared", homing_complete, 32'h0);
      apb(1'b1, `A_CTRL, 32'h00000002);
      wt(3);
      chk("abort_stop", motion_stop, 32'h1);
      chk("abort_done", homing_complete, 32'h0);
      final_report;
   end
endmodule
